/* File: hdl/i2cmr_map.svh */
// Register offsets, field positions and reset values of the I2C master
`ifndef I2CMR_MAP_SVH
`define I2CMR_MAP_SVH
`define I2CMR_A_CTRL 2'h0
`define I2CMR_A_STAT 2'h1
`define I2CMR_A_BUF 2'h2
`define I2CMR_A_BAUD 2'h3
`define I2CMR_C_EN 7
`define I2CMR_C_ACKST 6
`define I2CMR_C_ACK_DATA_BIT 5
`define I2CMR_C_ACK_SEQUENCE_ENABLE 4
`define I2CMR_C_RECEIVE_ENABLE_BIT 3
`define I2CMR_C_PEN 2
`define I2CMR_C_SEN 0
`define I2CMR_S_WRITE_COLLISION_FLAG 7
`define I2CMR_S_OV 6
`define I2CMR_S_STOPD 4
`define I2CMR_S_STARTD 3
`define I2CMR_S_BCL 2
`define I2CMR_S_PIF 1
`define I2CMR_S_BF 0
`define I2CMR_BAUD_RST 8'h04
`define I2CMR_BRG_ZERO 8'h00
`define I2CMR_BRG_ONE 8'h01
`define I2CMR_BYTE_ZERO 8'h00
`define I2CMR_BIT_FIRST 4'h0
`define I2CMR_BIT_ONE 4'h1
`define I2CMR_BIT_LAST 4'h7
`define I2CMR_BIT_ACK 4'h8
`endif

/* File: hdl/i2cmr_pkg.sv */
// Types shared by the I2C master receive, acknowledge and stop logic
package i2cmr_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    st_idle, st_start1, st_start2, st_lo, st_hi,
    st_stop1, st_stop2, st_stop3, st_stop4
  } i2cmr_state_type;
  // Kind of byte or bit sequence run by the low/high phases
  typedef enum logic [1:0] {op_tx, op_rx, op_ack} i2cmr_op_type;
endpackage

/* File: hdl/i2cmr_top.sv */
// I2C master sequencer: address send, byte receive, acknowledge, stop
`timescale 1ns/1ps
`default_nettype none
`include "i2cmr_map.svh"

// Notes on behaviour
// - Receive enable only accepted while idle
// - SCL toggles per baud rollover, SDA shifted in
// - After eighth clock: buffer load, flags, SCL low
// - Buffer full set on load, cleared on read
// - Overflow when byte completes with buffer full
// - Buffer write during receive: collision, no change
// - Buffer write during acknowledge: collision, no change
// - Buffer write during stop: collision, no change
// - Acknowledge drives SCL low, SDA ack data
// - Acknowledge: wait, release SCL, wait, SCL low, idle
// - Stop: SDA low, count, release SCL, then SDA
// - Stop seen sets flag, interrupt one period later
// - Address ack captured, interrupt after ninth clock
// - Interrupt after master ack bit clocked out
// - Reset disables port and aborts transfer
// - Start/stop seen cleared by reset or disable
// - Foreign stop raises interrupt flag when idle
// - SDA compared with intended level, collision flag
// - Baud reloads come from reload register
// - Ack status 0 acknowledged, 1 not
module i2cmr_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // Synchronisers; the meta stage feeds only the sync stage
  logic scl_meta_r, scl_sync_r, sda_meta_r, sda_sync_r, sda_dly_r;
  // Sequencer state
  i2cmr_pkg::i2cmr_state_type state_r;
  i2cmr_pkg::i2cmr_op_type op_r;
  logic [3:0] bitcnt_r; // Bit index within the sequence
  logic [7:0] brg_r; // Baud generator down counter
  logic [7:0] shift_r; // serial_shift_register
  logic scl_low_r, sda_low_r; // Pin pull-down requests
  logic ack_st_r; // ack_status_bit
  // Software-held control
  logic en_r, ack_dt_r;
  logic [7:0] baud_r; // baud_reload_register
  logic [7:0] buf_r; // serial_data_buffer
  // Status flags
  logic bf_r, ov_r, write_collision_flag_r, bcl_r, pif_r, startd_r, stopd_r;
  logic [7:0] rdata_r;
  // Decoded strobes and sequencer events
  logic ctrl_wr, stat_wr, buf_wr, buf_rd, cmd_wr, tx_go, write_collision_flag_ev;
  logic tick, hi_done, last_bit, col, start_ev, stop_ev;
  logic rx_done, tx_done, ack_done, tx_bf_clr, pif_ev;
  logic want_one, busy_ack, busy_rx, busy_stop, busy_start;

  // Open drain: the pins are only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;
  assign rdata = rdata_r;

  // Bus decode
  assign ctrl_wr = wr && (addr == `I2CMR_A_CTRL);
  assign stat_wr = wr && (addr == `I2CMR_A_STAT);
  assign buf_wr = wr && (addr == `I2CMR_A_BUF);
  assign buf_rd = rd && (addr == `I2CMR_A_BUF);
  assign cmd_wr = ctrl_wr && en_r && (state_r == i2cmr_pkg::st_idle);
  assign tx_go = buf_wr && en_r && (state_r == i2cmr_pkg::st_idle);
  // busy buffer write
  // Covers receive, acknowledge and stop alike, plus a disabled port
  assign write_collision_flag_ev = buf_wr && !tx_go;

  // Baud generator rolls over when it reaches zero
  assign tick = (brg_r == `I2CMR_BRG_ZERO);
  // High phase ends only once SCL really reads high (stretching)
  assign hi_done = (state_r == i2cmr_pkg::st_hi) && tick && scl_sync_r;
  assign last_bit = (op_r == i2cmr_pkg::op_ack) ||
    ((op_r == i2cmr_pkg::op_rx) && (bitcnt_r == `I2CMR_BIT_LAST)) ||
    ((op_r == i2cmr_pkg::op_tx) && (bitcnt_r == `I2CMR_BIT_ACK));
  assign want_one = !sda_low_r;
  // arbitration check
  // Address/data bits and our ack bit; the slave's ack slot is exempt
  assign col = (hi_done && want_one && !sda_sync_r &&
    (op_r != i2cmr_pkg::op_rx) &&
    !((op_r == i2cmr_pkg::op_tx) && (bitcnt_r == `I2CMR_BIT_ACK))) ||
    ((state_r == i2cmr_pkg::st_start1) && tick &&
    !(sda_sync_r && scl_sync_r));
  assign rx_done = hi_done && !col && last_bit &&
    (op_r == i2cmr_pkg::op_rx);
  assign tx_done = hi_done && !col && last_bit &&
    (op_r == i2cmr_pkg::op_tx);
  assign ack_done = hi_done && !col && (op_r == i2cmr_pkg::op_ack);
  assign tx_bf_clr = hi_done && (op_r == i2cmr_pkg::op_tx) &&
    (bitcnt_r == `I2CMR_BIT_LAST);
  // Bus condition detectors on the synchronised lines
  assign start_ev = sda_dly_r && !sda_sync_r && scl_sync_r;
  assign stop_ev = !sda_dly_r && sda_sync_r && scl_sync_r;
  assign pif_ev = rx_done || tx_done || ack_done ||
    ((state_r == i2cmr_pkg::st_start2) && tick) ||
    ((state_r == i2cmr_pkg::st_stop4) && tick) ||
    (stop_ev && (state_r == i2cmr_pkg::st_idle));
  // Enable bits read back as the running sequence
  assign busy_ack = (op_r == i2cmr_pkg::op_ack) &&
    ((state_r == i2cmr_pkg::st_lo) || (state_r == i2cmr_pkg::st_hi));
  assign busy_rx = (op_r == i2cmr_pkg::op_rx) &&
    ((state_r == i2cmr_pkg::st_lo) || (state_r == i2cmr_pkg::st_hi));
  assign busy_stop = (state_r == i2cmr_pkg::st_stop1) ||
    (state_r == i2cmr_pkg::st_stop2) ||
    (state_r == i2cmr_pkg::st_stop3) || (state_r == i2cmr_pkg::st_stop4);
  assign busy_start = (state_r == i2cmr_pkg::st_start1) ||
    (state_r == i2cmr_pkg::st_start2);

  // Pin synchronisers; the delayed stage gives edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_dly_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_sync_r <= scl_meta_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
      sda_dly_r <= sda_sync_r;
    end
  end

  // Software control: port enable, ack data, baud reload
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      ack_dt_r <= 1'b0;
      baud_r <= `I2CMR_BAUD_RST;
    end else begin
      if (ctrl_wr) begin
        en_r <= wdata[`I2CMR_C_EN];
        ack_dt_r <= wdata[`I2CMR_C_ACK_DATA_BIT];
      end
      if (wr && (addr == `I2CMR_A_BAUD)) begin
        baud_r <= wdata;
      end
    end
  end

  // Sequencer; reset or disable aborts everything and frees the lines
  always_ff @(posedge mclk) begin
    if (!rst_n || !en_r) begin
      state_r <= i2cmr_pkg::st_idle;
      op_r <= i2cmr_pkg::op_tx;
      bitcnt_r <= `I2CMR_BIT_FIRST;
      brg_r <= `I2CMR_BRG_ZERO;
      shift_r <= `I2CMR_BYTE_ZERO;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      ack_st_r <= 1'b0;
    end else begin
      // Count down; phase changes below reload
      if (brg_r != `I2CMR_BRG_ZERO) begin
        brg_r <= brg_r - `I2CMR_BRG_ONE;
      end
      case (state_r)
        i2cmr_pkg::st_idle: begin
          if (cmd_wr && wdata[`I2CMR_C_SEN]) begin
            state_r <= i2cmr_pkg::st_start1;
            sda_low_r <= 1'b0;
            scl_low_r <= 1'b0;
            brg_r <= baud_r;
          end else if (cmd_wr && wdata[`I2CMR_C_PEN]) begin
            state_r <= i2cmr_pkg::st_stop1;
            sda_low_r <= 1'b1;
            brg_r <= baud_r;
          end else if (cmd_wr && wdata[`I2CMR_C_RECEIVE_ENABLE_BIT]) begin
            state_r <= i2cmr_pkg::st_lo;
            op_r <= i2cmr_pkg::op_rx;
            bitcnt_r <= `I2CMR_BIT_FIRST;
            scl_low_r <= 1'b1;
            sda_low_r <= 1'b0;
            brg_r <= baud_r;
          end else if (cmd_wr && wdata[`I2CMR_C_ACK_SEQUENCE_ENABLE]) begin
            state_r <= i2cmr_pkg::st_lo;
            op_r <= i2cmr_pkg::op_ack;
            bitcnt_r <= `I2CMR_BIT_FIRST;
            scl_low_r <= 1'b1;
            sda_low_r <= !wdata[`I2CMR_C_ACK_DATA_BIT];
            brg_r <= baud_r;
          end else if (tx_go) begin
            // Address or data byte, MSB first
            state_r <= i2cmr_pkg::st_lo;
            op_r <= i2cmr_pkg::op_tx;
            bitcnt_r <= `I2CMR_BIT_FIRST;
            scl_low_r <= 1'b1;
            sda_low_r <= !wdata[7];
            shift_r <= wdata;
            brg_r <= baud_r;
          end
        end
        i2cmr_pkg::st_start1: begin
          if (tick && sda_sync_r && scl_sync_r) begin
            sda_low_r <= 1'b1;
            state_r <= i2cmr_pkg::st_start2;
            brg_r <= baud_r;
          end else if (tick) begin
            // Line already low: give up, bus left alone
            state_r <= i2cmr_pkg::st_idle;
          end
        end
        i2cmr_pkg::st_start2: begin
          if (tick) begin
            scl_low_r <= 1'b1;
            state_r <= i2cmr_pkg::st_idle;
          end
        end
        i2cmr_pkg::st_lo: begin
          if (tick) begin
            scl_low_r <= 1'b0;
            state_r <= i2cmr_pkg::st_hi;
            brg_r <= baud_r;
          end
        end
        i2cmr_pkg::st_hi: begin
          if (!scl_sync_r) begin
            // Held low by a slave: the high time starts once it lets go
            brg_r <= baud_r;
          end else if (tick && col) begin
            // Lost arbitration: release both lines
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            state_r <= i2cmr_pkg::st_idle;
          end else if (tick) begin
            scl_low_r <= 1'b1;
            brg_r <= baud_r;
            if (op_r == i2cmr_pkg::op_rx) begin
              shift_r <= {shift_r[6:0], sda_sync_r};
            end
            if ((op_r == i2cmr_pkg::op_tx) &&
                (bitcnt_r == `I2CMR_BIT_ACK)) begin
              ack_st_r <= sda_sync_r;
            end
            if (last_bit) begin
              state_r <= i2cmr_pkg::st_idle;
            end else begin
              state_r <= i2cmr_pkg::st_lo;
              bitcnt_r <= bitcnt_r + `I2CMR_BIT_ONE;
              if (op_r == i2cmr_pkg::op_tx) begin
                shift_r <= {shift_r[6:0], 1'b0};
              end
              // SDA changes with the falling SCL; ack slot released
              sda_low_r <= (op_r == i2cmr_pkg::op_tx) &&
                (bitcnt_r != `I2CMR_BIT_LAST) && !shift_r[6];
            end
          end
        end
        i2cmr_pkg::st_stop1: begin
          if (sda_sync_r) begin
            brg_r <= baud_r;
          end else if (tick) begin
            scl_low_r <= 1'b0;
            state_r <= i2cmr_pkg::st_stop2;
            brg_r <= baud_r;
          end
        end
        i2cmr_pkg::st_stop2: begin
          if (!scl_sync_r) begin
            brg_r <= baud_r;
          end else if (tick) begin
            sda_low_r <= 1'b0;
            state_r <= i2cmr_pkg::st_stop3;
          end
        end
        i2cmr_pkg::st_stop3: begin
          // Waits for the line to show the stop; a stuck SDA hangs here
          if (stop_ev) begin
            state_r <= i2cmr_pkg::st_stop4;
            brg_r <= baud_r;
          end
        end
        i2cmr_pkg::st_stop4: begin
          if (tick) begin
            state_r <= i2cmr_pkg::st_idle;
          end
        end
        default: begin
          state_r <= i2cmr_pkg::st_idle;
        end
      endcase
    end
  end

  // Buffer and buffer-full; an overrun keeps the unread byte
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buf_r <= `I2CMR_BYTE_ZERO;
      bf_r <= 1'b0;
    end else begin
      if (rx_done && !bf_r) begin
        buf_r <= {shift_r[6:0], sda_sync_r};
      end else if (tx_go) begin
        buf_r <= wdata;
      end
      // set on load, clear on read
      if (rx_done || tx_go) begin
        bf_r <= 1'b1;
      end else if (buf_rd || tx_bf_clr ||
          (col && op_r == i2cmr_pkg::op_tx)) begin
        bf_r <= 1'b0;
      end
    end
  end

  // Sticky flags: write one clears, a same-cycle event wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ov_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      bcl_r <= 1'b0;
      pif_r <= 1'b0;
    end else begin
      ov_r <= (rx_done && bf_r) ||
        (ov_r && !(stat_wr && wdata[`I2CMR_S_OV]));
      write_collision_flag_r <= write_collision_flag_ev ||
        (write_collision_flag_r && !(stat_wr && wdata[`I2CMR_S_WRITE_COLLISION_FLAG]));
      bcl_r <= col || (bcl_r && !(stat_wr && wdata[`I2CMR_S_BCL]));
      pif_r <= pif_ev || (pif_r && !(stat_wr && wdata[`I2CMR_S_PIF]));
    end
  end

  // Start and stop seen on the bus
  always_ff @(posedge mclk) begin
    if (!rst_n || !en_r) begin
      startd_r <= 1'b0;
      stopd_r <= 1'b0;
    end else if (start_ev) begin
      startd_r <= 1'b1;
      stopd_r <= 1'b0;
    end else if (stop_ev) begin
      startd_r <= 1'b0;
      stopd_r <= 1'b1;
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!rst_n || !rd) begin
      rdata_r <= `I2CMR_BYTE_ZERO;
    end else begin
      case (addr)
        `I2CMR_A_CTRL: rdata_r <= {en_r, ack_st_r, ack_dt_r, busy_ack,
          busy_rx, busy_stop, 1'b0, busy_start};
        `I2CMR_A_STAT: rdata_r <= {write_collision_flag_r, ov_r, 1'b0, stopd_r,
          startd_r, bcl_r, pif_r, bf_r};
        `I2CMR_A_BUF: rdata_r <= buf_r;
        default: rdata_r <= baud_r;
      endcase
    end
  end

  // Receive only ever enters from idle
  property p_rx_from_idle;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == i2cmr_pkg::st_lo && op_r == i2cmr_pkg::op_rx &&
     bitcnt_r == `I2CMR_BIT_FIRST && $changed(state_r))
    |-> $past(state_r) == i2cmr_pkg::st_idle;
  endproperty
  a_rx_from_idle: assert property (p_rx_from_idle)
    else $error("receive began outside idle");

  property p_rx_shift;
    @(posedge mclk) disable iff (!rst_n || !en_r)
    (hi_done && !col && op_r == i2cmr_pkg::op_rx)
    |=> shift_r[0] == $past(sda_sync_r);
  endproperty
  a_rx_shift: assert property (p_rx_shift)
    else $error("sampled SDA not shifted in");

  property p_rx_done;
    @(posedge mclk) disable iff (!rst_n || !en_r)
    rx_done |=> (state_r == i2cmr_pkg::st_idle) && scl_oe && bf_r &&
      pif_r && !busy_rx;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("byte end effects missing");

  property p_bf_read;
    @(posedge mclk) disable iff (!rst_n)
    (buf_rd && !rx_done) |=> !bf_r;
  endproperty
  a_bf_read: assert property (p_bf_read)
    else $error("buffer read left full flag");

  property p_overflow;
    @(posedge mclk) disable iff (!rst_n)
    (rx_done && bf_r) |=> ov_r && (buf_r == $past(buf_r));
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged");

  property p_write_collision_flag;
    @(posedge mclk) disable iff (!rst_n)
    (buf_wr && state_r != i2cmr_pkg::st_idle && !rx_done)
    |=> write_collision_flag_r && (buf_r == $past(buf_r));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("busy buffer write not refused");

  property p_ack_drive;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == i2cmr_pkg::st_lo && op_r == i2cmr_pkg::op_ack)
    |-> scl_oe && (sda_oe == !ack_dt_r);
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack bit not presented");

  property p_ack_status;
    @(posedge mclk) disable iff (!rst_n || !en_r)
    tx_done |=> (ack_st_r == $past(sda_sync_r)) && pif_r;
  endproperty
  a_ack_status: assert property (p_ack_status)
    else $error("slave ack not captured");

  property p_disable_clr;
    @(posedge mclk) disable iff (!rst_n)
    !en_r |=> !startd_r && !stopd_r && !scl_oe && !sda_oe;
  endproperty
  a_disable_clr: assert property (p_disable_clr)
    else $error("disable left state behind");

  property p_collision;
    @(posedge mclk) disable iff (!rst_n || !en_r)
    col |=> bcl_r && (state_r == i2cmr_pkg::st_idle);
  endproperty
  a_collision: assert property (p_collision)
    else $error("collision not handled");
endmodule
`default_nettype wire

/* File: sim/i2cmr_slave.sv */
// Behavioural I2C slave that answers reads, with optional clock stretch
`timescale 1ns/1ps
`default_nettype none
module i2cmr_slave #(
  parameter logic [6:0] dev_addr = 7'h2a // Bus address of this slave
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  input wire logic [15:0] stretch_ns,
  output logic scl_oe,
  output logic sda_oe
);
  // Both lines released until a frame starts
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // One frame per start, cut short by any stop on the wire
  always begin
    @(negedge sda iff scl === 1'b1);
    fork
      frame();
      @(posedge sda iff scl === 1'b1);
    join_any
    disable fork;
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // Address in, ack, then bytes out until the master declines one
  task automatic frame();
    logic [7:0] a;
    logic [7:0] d;
    logic more;
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      a = {a[6:0], sda};
    end
    @(negedge scl);
    // Foreign address or a write: stay silent until the stop
    if (a[7:1] != dev_addr || !a[0]) begin
      wait (1'b0);
    end
    sda_oe = 1'b1;
    @(negedge scl);
    more = 1'b1;
    while (more) begin
      // Byte is latched at its first bit so the bench may queue the next
      d = tx_byte;
      for (int i = 7; i >= 0; i--) begin
        sda_oe = !d[i];
        // Slow mode: hold SCL low past the master's own low phase
        if (stretch_ns != 16'h0000) begin
          scl_oe = 1'b1;
          #(stretch_ns);
          scl_oe = 1'b0;
        end
        @(negedge scl);
      end
      sda_oe = 1'b0;
      @(posedge scl);
      more = !sda;
      @(negedge scl);
    end
    wait (1'b0);
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench: start, address, reads, ack/nack, stop, reset, collision
`timescale 1ns/1ps
`default_nettype none
`include "i2cmr_map.svh"
module testbench;
  typedef struct {logic [1:0] a; logic [7:0] e;
    logic [7:0] m;} i2cmr_note_type;
  logic mclk = 1'b0; // 10 MHz system clock
  logic rst_n = 1'b0; // Held low for three cycles
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic peek = 1'b0; // Polling read, not compared
  logic rd_seen = 1'b0; // Read data due this cycle
  logic [7:0] rdata;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic scl, sda; // Wire levels with pull-ups
  logic x_sda_oe = 1'b0; // Second master pulling SDA low
  logic [7:0] tx_byte = 8'h00; // Next byte the slave sends
  logic [15:0] stretch = 16'h0000; // Slave stretch, 0 = prompt
  logic [7:0] b[4]; // Bytes handed to the slave
  i2cmr_note_type notes[$]; // Expected read results, oldest first
  i2cmr_note_type nt;
  string rn[4] = '{"ctrl", "stat", "buf", "baud"};
  int n_fail = 0;
  int n_tests = 0;
  int seed = 49;

  // Open-drain wires: low if any party pulls
  assign scl = !(scl_oe | s_scl_oe);
  assign sda = !(sda_oe | s_sda_oe | x_sda_oe);

  always #50 mclk = ~mclk;

  i2cmr_top i2cmr_top_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));

  i2cmr_slave #(.dev_addr(7'h2a)) i2cmr_slave_inst (.scl(scl), .sda(sda),
    .tx_byte(tx_byte), .stretch_ns(stretch), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe));

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) rd_seen <= rd && !peek;

  // Compare each read result with the oldest note
  always @(negedge mclk) begin
    if (rd_seen) begin
      nt = notes.pop_front();
      n_tests++;
      if ((rdata & nt.m) !== nt.e) begin
        n_fail++;
        $display("ERROR %s expected %h seen %h", rn[nt.a], nt.e, rdata & nt.m);
      end
    end
  end

  // One write cycle on the register port
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // One read cycle; the expectation goes to the queue first
  task automatic rreg(input logic [1:0] a, input logic [7:0] e,
      input logic [7:0] m);
    notes.push_back('{a, e, m});
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  // Immediate pin comparison
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Poll status until the interrupt flag is up, bounded
  task automatic wait_pif();
    for (int k = 0; k < 3000; k++) begin
      @(posedge mclk);
      addr <= `I2CMR_A_STAT;
      rd <= 1'b1;
      peek <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      peek <= 1'b0;
      @(negedge mclk);
      if (rdata[`I2CMR_S_PIF] === 1'b1) return;
    end
    n_fail++;
    $display("ERROR port_interrupt expected 1 seen 0");
    test_done();
  endtask

  task automatic end_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, n_fail);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    foreach (b[i]) b[i] = 8'($random(seed));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(`I2CMR_A_CTRL, 8'h00, 8'hff);
    rreg(`I2CMR_A_STAT, 8'h00, 8'hff);
    rreg(`I2CMR_A_BAUD, 8'h04, 8'hff);
    wreg(`I2CMR_A_BAUD, 8'h03);
    rreg(`I2CMR_A_BAUD, 8'h03, 8'hff);
    end_test("reset");
    // bus is free: start seen set, stop seen clear
    wreg(`I2CMR_A_CTRL, 8'h80);
    wreg(`I2CMR_A_CTRL, 8'h81);
    wait_pif();
    wreg(`I2CMR_A_STAT, 8'h02);
    rreg(`I2CMR_A_STAT, 8'h08, 8'h1a);
    // address with read bit, receive only after its interrupt
    tx_byte <= b[0];
    wreg(`I2CMR_A_BUF, 8'h55);
    wreg(`I2CMR_A_CTRL, 8'h88);
    wait_pif();
    rreg(`I2CMR_A_CTRL, 8'h00, 8'h48);
    end_test("address");
    // Middle byte stretched and left unread so the last one overflows
    for (int i = 0; i < 3; i++) begin
      stretch <= (i == 1) ? 16'h0258 : 16'h0000;
      wreg(`I2CMR_A_STAT, 8'hc2);
      wreg(`I2CMR_A_CTRL, 8'h88);
      rreg(`I2CMR_A_CTRL, 8'h08, 8'h08);
      wreg(`I2CMR_A_BUF, 8'h5a);
      rreg(`I2CMR_A_STAT, 8'h80, 8'h80);
      wait_pif();
      chk1("scl_oe", 1'b1, scl_oe);
      rreg(`I2CMR_A_STAT, (i == 2) ? 8'h41 : 8'h01, 8'h41);
      rreg(`I2CMR_A_CTRL, 8'h00, 8'h08);
      if (i != 1) begin
        rreg(`I2CMR_A_BUF, (i == 2) ? b[1] : b[0], 8'hff);
        rreg(`I2CMR_A_STAT, 8'h00, 8'h01);
      end
      tx_byte <= b[i + 1];
      wreg(`I2CMR_A_STAT, 8'hc2);
      // ack data chosen in the same write, nack on the last byte
      wreg(`I2CMR_A_CTRL, (i == 2) ? 8'hb0 : 8'h90);
      @(negedge mclk);
      chk1("sda_oe", i != 2, sda_oe);
      chk1("scl_oe", 1'b1, scl_oe);
      wreg(`I2CMR_A_BUF, 8'h3c);
      rreg(`I2CMR_A_STAT, 8'h80, 8'h80);
      wait_pif();
      chk1("scl_oe", 1'b1, scl_oe);
      rreg(`I2CMR_A_CTRL, 8'h00, 8'h10);
      end_test("byte");
    end
    wreg(`I2CMR_A_STAT, 8'hc2);
    wreg(`I2CMR_A_CTRL, 8'h84);
    wreg(`I2CMR_A_BUF, 8'h33);
    rreg(`I2CMR_A_STAT, 8'h80, 8'h80);
    wait_pif();
    rreg(`I2CMR_A_STAT, 8'h12, 8'h12);
    rreg(`I2CMR_A_CTRL, 8'h00, 8'h04);
    @(negedge mclk);
    chk1("scl_oe", 1'b0, scl_oe);
    chk1("sda_oe", 1'b0, sda_oe);
    rreg(`I2CMR_A_BUF, b[1], 8'hff);
    wreg(`I2CMR_A_CTRL, 8'h00);
    rreg(`I2CMR_A_STAT, 8'h00, 8'h18);
    end_test("stop");
    // Reset in mid-address must free both lines and disable the port
    wreg(`I2CMR_A_CTRL, 8'h80);
    // Interrupt flag still up from the stop: clear it before waiting
    wreg(`I2CMR_A_STAT, 8'h02);
    wreg(`I2CMR_A_CTRL, 8'h81);
    wait_pif();
    wreg(`I2CMR_A_BUF, 8'h55);
    repeat (10) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk1("scl_oe", 1'b0, scl_oe);
    chk1("sda_oe", 1'b0, sda_oe);
    rreg(`I2CMR_A_CTRL, 8'h00, 8'hff);
    rreg(`I2CMR_A_STAT, 8'h00, 8'h18);
    end_test("abort");
    // Another master holds SDA low: our start is refused, its stop seen
    wreg(`I2CMR_A_CTRL, 8'h80);
    x_sda_oe <= 1'b1;
    repeat (3) @(posedge mclk);
    wreg(`I2CMR_A_CTRL, 8'h81);
    repeat (8) @(posedge mclk);
    rreg(`I2CMR_A_STAT, 8'h0c, 8'h1e);
    x_sda_oe <= 1'b0;
    repeat (6) @(posedge mclk);
    rreg(`I2CMR_A_STAT, 8'h16, 8'h1e);
    end_test("collision");
    repeat (3) @(posedge mclk);
    test_done();
  end
endmodule
`default_nettype wire
